//--- rtl/cbu_branch_unit.v
// Conditional branch unit: tests one status flag, or N xor V for the signed pair, per branch opcode, computes target.
// Assumes the decoder presents op_i with start_i for one cycle and holds off new
// starts while busy_o is high; flags and pc are stable with start_i.
`timescale 1ns/1ps
`include "cbu_regs.vh"

module cbu_branch_unit (
    // Clock and reset
    input wire sys_clk_i,
    input wire arst_n_i,
    // Decoder request
    input wire start_i,
    input wire [`CBU_OP_W-1:0] op_i,
    input wire [`CBU_OFS_W-1:0] offset_i,
    input wire [`CBU_PC_W-1:0] pc_i,
    // Status flags
    input wire flag_c_i,
    input wire flag_n_i,
    input wire flag_v_i,
    input wire flag_h_i,
    input wire flag_t_i,
    // Program counter update
    output wire pc_load_o,
    output wire [`CBU_PC_W-1:0] pc_next_o,
    output wire taken_o,
    output wire done_o,
    output wire busy_o
);

    // Timing at a glance
    // Request edge: start_i with a known opcode while idle
    // Not taken: load and done pulse right after the request edge
    // Not taken: pc_next_o is the branch address plus one
    // Taken: busy_o high for one cycle after the request edge
    // Taken: load and done pulse in the cycle after busy_o
    // Taken: pc_next_o is address plus signed offset plus one
    // taken_o and pc_next_o hold until the next load pulse
    // done_o always pulses together with pc_load_o
    //
    // Refusals
    // Opcode zero and unassigned codes give no answer at all
    // Requests while busy_o is high are dropped silently
    // Caller must present a dropped request again itself
    //
    // Back to back
    // A not-taken branch may be followed at the very next edge
    // After a taken one, the cycle with done_o high may start anew
    //
    // Flags and pc
    // Flags, pc and offset are read only at the request edge
    // Target is latched then, so inputs may move during busy_o
    // No flag is ever written; the block has no flag outputs
    //
    // Limitations
    // Offset reaches -64 to +63 around the next address
    // Sums wrap silently modulo the pc width, no error flag
    // Interrupt-flag and bit-indexed branch forms live elsewhere
    // Registered outputs keep the pc path free of glitches
    // Cost: fall-through spends one cycle a bypass would save

    // Sequencer state codes
    localparam ST_IDLE = 1'b0;
    localparam ST_TAKEN = 1'b1;

    reg state_ff;
    reg pc_load_ff;
    reg [`CBU_PC_W-1:0] pc_next_ff;
    reg taken_ff;
    reg done_ff;
    reg busy_ff;
    reg [`CBU_PC_W-1:0] target_ff;

    // Next values of the registers
    reg nxt_state;
    reg nxt_pc_load;
    reg [`CBU_PC_W-1:0] nxt_pc_next;
    reg nxt_taken;
    reg nxt_done;
    reg nxt_busy;
    reg [`CBU_PC_W-1:0] nxt_target;

    // Flag conditions, one per test
    wire cond_c_clr;
    wire cond_c_set;
    wire cond_n_set;
    wire cond_n_clr;
    wire cond_sgn_lt;
    wire cond_sgn_ge;
    wire cond_h_set;
    wire cond_h_clr;
    wire cond_t_set;
    wire accept;

    reg cond;
    reg valid_op;
    wire [`CBU_PC_W-1:0] ofs_ext;
    wire [`CBU_PC_W-1:0] target;
    wire [`CBU_PC_W-1:0] fall_pc;

    // Sign extend so backward branches subtract
    assign ofs_ext = {{(`CBU_PC_W-`CBU_OFS_W){offset_i[`CBU_OFS_W-1]}}, offset_i};

    // Sum truncated to pc width: wraps silently past either end
    assign target = pc_i + ofs_ext + 16'h0001;
    assign fall_pc = pc_i + 16'h0001;

    // Flag tests; signed compare uses negative xor overflow
    assign cond_c_clr = ~flag_c_i;
    assign cond_c_set = flag_c_i;
    assign cond_n_set = flag_n_i;
    assign cond_n_clr = ~flag_n_i;
    assign cond_sgn_lt = flag_n_i ^ flag_v_i;
    assign cond_sgn_ge = ~cond_sgn_lt;
    assign cond_h_set = flag_h_i;
    assign cond_h_clr = ~flag_h_i;
    assign cond_t_set = flag_t_i;

    // Only an idle sequencer takes a request; later ones are dropped
    assign accept = start_i && valid_op && (state_ff == ST_IDLE);

    // Condition select per opcode; flags are only read, never written
    always @* begin
        cond = 1'b0;
        valid_op = 1'b1;
        case (op_i)
            `CBU_OP_CARRY_CLEAR: cond = cond_c_clr;
            `CBU_OP_SAME_OR_HIGHER: cond = cond_c_clr;
            `CBU_OP_UNSIGNED_LOWER: cond = cond_c_set;
            `CBU_OP_ON_MINUS: cond = cond_n_set;
            `CBU_OP_ON_PLUS: cond = cond_n_clr;
            `CBU_OP_SIGNED_GE: cond = cond_sgn_ge;
            `CBU_OP_SIGNED_LT: cond = cond_sgn_lt;
            `CBU_OP_HALF_SET: cond = cond_h_set;
            `CBU_OP_HALF_CLEAR: cond = cond_h_clr;
            `CBU_OP_TBIT_SET: cond = cond_t_set;
            default: valid_op = 1'b0;
        endcase
    end

    // Two-state sequencer: taken branch spends one extra cycle refilling fetch
    always @* begin
        nxt_state = state_ff;
        nxt_pc_load = 1'b0;
        nxt_pc_next = pc_next_ff;
        nxt_taken = taken_ff;
        nxt_done = 1'b0;
        nxt_busy = busy_ff;
        nxt_target = target_ff;
        case (state_ff)
            ST_IDLE: begin
                if (accept) begin
                    if (cond) begin
                        // Hold target, finish next cycle
                        nxt_target = target;
                        nxt_busy = 1'b1;
                        nxt_state = ST_TAKEN;
                    end else begin
                        // Fall through answers at the edge after the request
                        nxt_pc_load = 1'b1;
                        nxt_pc_next = fall_pc;
                        nxt_taken = 1'b0;
                        nxt_done = 1'b1;
                    end
                end
            end
            ST_TAKEN: begin
                // Requests seen now are dropped by the idle-only accept
                nxt_pc_load = 1'b1;
                nxt_pc_next = target_ff;
                nxt_taken = 1'b1;
                nxt_done = 1'b1;
                nxt_busy = 1'b0;
                nxt_state = ST_IDLE;
            end
            default: begin
                nxt_state = ST_IDLE;
                nxt_busy = 1'b0;
            end
        endcase
    end

    // State and output registers; reset loads constants only
    always @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_ff <= ST_IDLE;
            pc_load_ff <= 1'b0;
            pc_next_ff <= `CBU_PC_RST;
            taken_ff <= 1'b0;
            done_ff <= 1'b0;
            busy_ff <= 1'b0;
            target_ff <= `CBU_PC_RST;
        end else begin
            state_ff <= nxt_state;
            pc_load_ff <= nxt_pc_load;
            pc_next_ff <= nxt_pc_next;
            taken_ff <= nxt_taken;
            done_ff <= nxt_done;
            busy_ff <= nxt_busy;
            target_ff <= nxt_target;
        end
    end

    // Registered outputs
    assign pc_load_o = pc_load_ff;
    assign pc_next_o = pc_next_ff;
    assign taken_o = taken_ff;
    assign done_o = done_ff;
    assign busy_o = busy_ff;

endmodule // cbu_branch_unit

//--- rtl/cbu_regs.vh
// Constants for the conditional branch unit: opcode codes, widths, cycle counts.
// Assumes inclusion by bare name from the design file only.
`ifndef CBU_REGS_VH
`define CBU_REGS_VH

// Widths
`define CBU_PC_W 16
`define CBU_OFS_W 7
`define CBU_OP_W 4

// Branch opcode codes presented by the decoder
`define CBU_OP_NONE 4'h0
`define CBU_OP_CARRY_CLEAR 4'h1
`define CBU_OP_SAME_OR_HIGHER 4'h2
`define CBU_OP_UNSIGNED_LOWER 4'h3
`define CBU_OP_ON_MINUS 4'h4
`define CBU_OP_ON_PLUS 4'h5
`define CBU_OP_SIGNED_GE 4'h6
`define CBU_OP_SIGNED_LT 4'h7
`define CBU_OP_HALF_SET 4'h8
`define CBU_OP_HALF_CLEAR 4'h9
`define CBU_OP_TBIT_SET 4'hA

// Cycle counts
`define CBU_CYC_NOT_TAKEN 2'h1
`define CBU_CYC_TAKEN 2'h2

// Reset values
`define CBU_PC_RST 16'h0000

`endif

//--- sim/cbu_branch_assertions.sv
// Port-level checker for the conditional branch unit.
// Assumes it is bound to cbu_branch_unit and sees only its ports.
`timescale 1ns/1ps
module cbu_branch_assertions (
    input wire sys_clk_i, arst_n_i, start_i, flag_c_i, flag_n_i, flag_v_i, flag_h_i, flag_t_i,
    input wire [3:0] op_i,
    input wire [6:0] offset_i,
    input wire [15:0] pc_i, pc_next_o,
    input wire pc_load_o, taken_o, done_o, busy_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!arst_n_i);
    // Condition bit per opcode, bit index equals op code
    wire nv = flag_n_i ^ flag_v_i;
    wire [10:0] cv = {flag_t_i, !flag_h_i, flag_h_i, nv, !nv, !flag_n_i, flag_n_i,
        flag_c_i, !flag_c_i, !flag_c_i, 1'b0};
    wire ok = op_i >= 4'h1 && op_i <= 4'hA;
    wire go = start_i && !busy_o && ok;
    wire cnd = cv[op_i];
    reg [15:0] tgt_ff, fal_ff;
    // Targets captured at the taking edge, since pc_i may move afterwards
    always @(posedge sys_clk_i) begin
        if (go) begin
            tgt_ff <= pc_i + {{9{offset_i[6]}}, offset_i} + 16'h0001;
            fal_ff <= pc_i + 16'h0001;
        end
    end
    property p_nt; go && !cnd |=> pc_load_o && done_o && !taken_o && !busy_o; endproperty
    a_nt: assert property (p_nt) else $error("not-taken answer wrong");
    property p_tk; go && cnd |=> busy_o && !pc_load_o ##1 pc_load_o && taken_o; endproperty
    a_tk: assert property (p_tk) else $error("taken answer wrong");
    property p_tg; pc_load_o && taken_o |-> pc_next_o == tgt_ff; endproperty
    a_tg: assert property (p_tg) else $error("target wrong");
    property p_ft; pc_load_o && !taken_o |-> pc_next_o == fal_ff; endproperty
    a_ft: assert property (p_ft) else $error("fall-through wrong");
    property p_rf; start_i && !busy_o && !ok |=> !pc_load_o && !busy_o; endproperty
    a_rf: assert property (p_rf) else $error("bad opcode answered");
    property p_dn; done_o == pc_load_o; endproperty
    a_dn: assert property (p_dn) else $error("done and load differ");
    property p_bz; busy_o |=> pc_load_o && !busy_o; endproperty
    a_bz: assert property (p_bz) else $error("busy not one cycle");
    property p_st; !pc_load_o |-> $stable(pc_next_o) && $stable(taken_o); endproperty
    a_st: assert property (p_st) else $error("outputs moved");
endmodule // cbu_branch_assertions
bind cbu_branch_unit cbu_branch_assertions chk_u (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i),
    .start_i(start_i), .flag_c_i(flag_c_i), .flag_n_i(flag_n_i), .flag_v_i(flag_v_i),
    .flag_h_i(flag_h_i), .flag_t_i(flag_t_i), .op_i(op_i), .offset_i(offset_i), .pc_i(pc_i),
    .pc_next_o(pc_next_o), .pc_load_o(pc_load_o), .taken_o(taken_o), .done_o(done_o),
    .busy_o(busy_o));

//--- sim/conditional_branch_unit_tb.sv
// Self-checking bench for the conditional branch unit.
// Assumes the checker file is compiled alongside and binds itself.
`timescale 1ns/1ps
module conditional_branch_unit_tb;
    reg sys_clk_i = 0, arst_n_i = 0, start_i = 0;
    reg flag_c_i = 0, flag_n_i = 0, flag_v_i = 0, flag_h_i = 0, flag_t_i = 0;
    reg [3:0] op_i = 4'h0;
    reg [6:0] offset_i = 7'h00;
    reg [15:0] pc_i = 16'h0000, exp_pc;
    wire pc_load_o, taken_o, done_o, busy_o;
    wire [15:0] pc_next_o;
    integer errors = 0, comparisons = 0, cyc = 0, i;
    // Row: op, flags c n v h t, bit1 no answer, bit0 taken
    reg [11:0] rows [0:21] = '{12'h180, 12'h101, 12'h201, 12'h280, 12'h381, 12'h300, 12'h441,
        12'h400, 12'h581, 12'h540, 12'h661, 12'h620, 12'h741, 12'h760, 12'h811, 12'h808,
        12'h909, 12'h910, 12'hA09, 12'hA10, 12'h0FA, 12'hFFA};
    always #2.5 sys_clk_i = ~sys_clk_i;
    cbu_branch_unit dut_u (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .start_i(start_i),
        .op_i(op_i), .offset_i(offset_i), .pc_i(pc_i), .flag_c_i(flag_c_i), .flag_n_i(flag_n_i),
        .flag_v_i(flag_v_i), .flag_h_i(flag_h_i), .flag_t_i(flag_t_i), .pc_load_o(pc_load_o),
        .pc_next_o(pc_next_o), .taken_o(taken_o), .done_o(done_o), .busy_o(busy_o));
    task chk(input [15:0] got, input [15:0] exp); begin
        comparisons = comparisons + 1;
        if (got !== exp) begin
            errors = errors + 1;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    end endtask
    task final_report; begin
        $display("errors=%0d comparisons=%0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    end endtask
    // One request; extra edge waited only for a taken branch
    task issue(input [11:0] r, input [6:0] k, input [15:0] p); begin
        @(posedge sys_clk_i);
        start_i <= 1'b1; op_i <= r[11:8]; offset_i <= k; pc_i <= p;
        {flag_c_i, flag_n_i, flag_v_i, flag_h_i, flag_t_i} <= r[7:3];
        exp_pc = r[0] ? p + {{9{k[6]}}, k} + 16'h0001 : p + 16'h0001;
        @(posedge sys_clk_i) start_i <= 1'b0;
        #1 chk({busy_o, pc_load_o, done_o}, {r[0], {2{!r[1] && !r[0]}}});
        if (r[0]) @(posedge sys_clk_i) #1 chk({busy_o, pc_load_o, done_o}, 16'h0003);
        if (!r[1]) chk(pc_next_o ^ {taken_o, 15'h0000}, exp_pc ^ {r[0], 15'h0000});
    end endtask
    // Reset values, table of opcodes, then a wrapping backward branch
    initial begin
        @(posedge sys_clk_i) #1 chk({busy_o, taken_o, pc_load_o, done_o, pc_next_o[11:0]}, 16'h0000);
        @(posedge sys_clk_i) arst_n_i <= 1'b1;
        #1 chk({busy_o, taken_o, pc_load_o, done_o}, 16'h0000);
        for (i = 0; i < 22; i = i + 1) begin
            issue(rows[i], i[0] ? 7'h40 : 7'h3F, 16'h1FFF * i[15:0]);
        end
        issue(12'h101, 7'h7D, 16'h0001);
        // Start held into the busy cycle is dropped: one answer only
        @(posedge sys_clk_i);
        start_i <= 1'b1; op_i <= 4'h1; offset_i <= 7'h02; pc_i <= 16'h0100;
        {flag_c_i, flag_n_i, flag_v_i, flag_h_i, flag_t_i} <= 5'h00;
        @(posedge sys_clk_i) op_i <= 4'h3;
        @(posedge sys_clk_i) start_i <= 1'b0;
        #1 chk({taken_o, pc_load_o, done_o, busy_o}, 16'h000E);
        chk(pc_next_o, 16'h0103);
        @(posedge sys_clk_i) #1 chk({busy_o, pc_load_o, done_o}, 16'h0000);
        // Two not-taken requests back to back
        @(posedge sys_clk_i);
        start_i <= 1'b1; op_i <= 4'h2; pc_i <= 16'h0200; flag_c_i <= 1'b1;
        @(posedge sys_clk_i) pc_i <= 16'h0300;
        #1 chk({pc_next_o, pc_load_o}, 17'h00403);
        @(posedge sys_clk_i) start_i <= 1'b0;
        #1 chk({pc_next_o[14:0], pc_load_o}, 16'h0603);
        chk(taken_o, 16'h0000);
        // Reset in mid-run during a taken branch, then a clean request
        @(posedge sys_clk_i);
        start_i <= 1'b1; op_i <= 4'h1; flag_c_i <= 1'b0;
        @(posedge sys_clk_i) begin
            start_i <= 1'b0;
            arst_n_i <= 1'b0;
        end
        #1 chk({busy_o, taken_o, pc_load_o, done_o, pc_next_o[11:0]}, 16'h0000);
        repeat (2) @(posedge sys_clk_i);
        arst_n_i <= 1'b1;
        @(posedge sys_clk_i) #1 chk({busy_o, taken_o, pc_load_o, done_o}, 16'h0000);
        issue(12'h101, 7'h01, 16'h0010);
        final_report;
    end
    // Hang guard, well above the roughly 75 cycles the sequence needs
    always @(posedge sys_clk_i) begin
        cyc = cyc + 1;
        if (cyc == 1000) begin
            errors = errors + 1;
            final_report;
        end
    end
endmodule // conditional_branch_unit_tb
